// ---- hw/refresh_pkg.sv ----
// Purpose: shared constants and types for the DRAM refresh controller
// Assumes: 20 MHz hclk, one hclk per processor clock state
// Notes: register map, reset values, refresh cycle states
// Operation
// - 8-bit row address, timed refresh insertion
// - refresh starts at machine cycle boundary
// - drive row address, pull strobe low
// - wait input ignored during refresh
// - bit 7 enables refresh, resets to 1
// - bit 6 adds third clock, resets 1
// - bits 1:0 pick 10/20/40/80 states
// - no refresh in release, sleep, wait
// - interval timer runs during bus release
// - sleep request held, serviced after sleep
// - address advances only per real cycle
// - one pending request kept over release
package refresh_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;

   // Control field positions
   localparam int ON_BIT = 7;
   localparam int EXTRA_WAIT_BIT = 6;
   localparam int SEL_HI_BIT = 1;
   localparam int SEL_LO_BIT = 0;

   // Control reset: enabled, extra wait, shortest interval
   localparam logic [7:0] CONTROL_RESET = 8'hC0;
   // Writable bits of the control register
   localparam logic [7:0] CONTROL_MASK = 8'hC3;

   // Status field positions
   localparam int STAT_PENDING_BIT = 8;
   localparam int STAT_ACTIVE_BIT = 9;

   // Interval lengths in clock states
   localparam logic [6:0] INTERVAL_0 = 7'h0A;
   localparam logic [6:0] INTERVAL_1 = 7'h14;
   localparam logic [6:0] INTERVAL_2 = 7'h28;
   localparam logic [6:0] INTERVAL_3 = 7'h50;

   // Refresh row address after reset
   localparam logic [7:0] ROW_RESET = 8'h00;

   // Refresh cycle states, one-hot
   typedef enum logic [3:0] {
      RF_IDLE = 4'h1,
      RF_T1 = 4'h2,
      RF_TRW = 4'h4,
      RF_T2 = 4'h8
   } rf_state_t;

   // What the refresh cycle puts on the memory bus
   typedef struct packed {
      logic refresh_n;
      logic addr_oe;
      logic [7:0] row;
      logic strobe_inhibit;
   } rf_bus_t;

endpackage : refresh_pkg

// ---- hw/pin_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to hclk
// Notes: only the second stage may be read by logic
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins in, synchronised out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);

   // First stage, read only by the second
   logic [WIDTH-1:0] meta;

   // Both stages in one register process
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= INIT;
         pin_out <= INIT;
      end else begin
         meta <= pin_in;
         pin_out <= meta;
      end
   end

endmodule : pin_sync

// ---- hw/refresh_interval_timer.sv ----
// Purpose: free-running refresh interval timer
// Assumes: counts one clock state per hclk
// Notes: keeps running whatever the bus does
`timescale 1ns/100ps
module refresh_interval_timer
   import refresh_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Interval select from the control register
   input wire logic [1:0] select,
   // One-cycle refresh request
   output logic tick
);

   // State counter and its next value
   logic [6:0] count;
   logic [6:0] next_count;
   logic [6:0] limit;

   // Interval lookup
   always_comb begin
      unique case (select)
         2'h0: limit = INTERVAL_0;
         2'h1: limit = INTERVAL_1;
         2'h2: limit = INTERVAL_2;
         2'h3: limit = INTERVAL_3;
      endcase
   end

   // A shortened interval past the count fires at once, no long wrap
   always_comb begin
      tick = (count >= limit - 7'h01);
      next_count = tick ? 7'h00 : count + 7'h01;
   end

   // Count register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 7'h00;
      end else begin
         count <= next_count;
      end
   end

   a_timer_restart:
      assert property (@(posedge hclk) disable iff (!hresetn)
         tick |=> count == 7'h00)
      else $error("timer did not restart after tick");

   a_timer_runs:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !tick |=> count == $past(count) + 7'h01)
      else $error("timer stalled");

endmodule : refresh_interval_timer

// ---- hw/dram_refresh_control.sv ----
// Purpose: DRAM refresh controller with AHB-Lite register access
// Assumes: CPU status inputs share hclk; wait pin is asynchronous
// Notes: zero-wait slave, reads answered from a register
`timescale 1ns/100ps
module dram_refresh_control
   import refresh_pkg::*;
(
   // AHB-Lite clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // CPU status on hclk
   input wire logic cycle_boundary,
   input wire logic bus_released,
   input wire logic sleep_mode,
   input wire logic wait_gen_active,
   // External wait pin
   input wire logic wait_n,
   // CPU control
   output logic cpu_hold,
   output logic cpu_wait,
   // Memory bus side
   output logic refresh_n,
   output logic addr_oe,
   output logic [7:0] row_addr,
   output logic strobe_inhibit
);

   // Control register and its next value
   logic [7:0] refresh_control;
   logic [7:0] next_control;
   // Captured address phase
   logic wr_pend;
   logic next_wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic [31:0] next_rdata;
   // Refresh engine state
   rf_state_t state;
   rf_state_t next_state;
   logic pending;
   logic next_pending;
   logic [7:0] row;
   logic [7:0] next_row;
   // Helpers
   logic tick;
   logic wait_pin;
   logic access;
   logic start;
   logic cycle_end;
   logic blocked;
   logic active;
   rf_bus_t bus;

   // Named control fields
   logic refresh_on_bit;
   logic refresh_extra_wait_bit;
   logic interval_select_hi;
   logic interval_select_lo;
   assign refresh_on_bit = refresh_control[ON_BIT];
   assign refresh_extra_wait_bit = refresh_control[EXTRA_WAIT_BIT];
   assign interval_select_hi = refresh_control[SEL_HI_BIT];
   assign interval_select_lo = refresh_control[SEL_LO_BIT];

   // Wait pin crosses in through two flops, idle high
   pin_sync #(
      .WIDTH(1),
      .INIT(1'h1)
   ) u_wait_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(wait_n),
      .pin_out(wait_pin)
   );

   // Interval timer runs regardless of bus ownership
   refresh_interval_timer u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .select({interval_select_hi, interval_select_lo}),
      .tick(tick)
   );

   // Slave never stalls and never errors
   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   // Only a NONSEQ or SEQ with hready starts a transfer
   assign access = hsel & htrans[1] & hready;

   // Bus slave: write capture, read data, control update
   always_comb begin
      next_control = refresh_control;
      next_wr_pend = access & hwrite;
      next_wr_addr = access ? haddr : wr_addr;
      next_rdata = hrdata;
      // Write lands in the data phase
      if (wr_pend && wr_addr == OFS_CONTROL) begin
         next_control = hwdata[7:0] & CONTROL_MASK;
      end
      // Read data set up from the address phase
      if (access && !hwrite) begin
         next_rdata = 32'h0000_0000;
         if (haddr == OFS_CONTROL) begin
            next_rdata[7:0] = next_control;
         end else if (haddr == OFS_STATUS) begin
            next_rdata[7:0] = row;
            next_rdata[STAT_PENDING_BIT] = pending;
            next_rdata[STAT_ACTIVE_BIT] = active;
         end
         // Unmapped addresses read zero
      end
   end

   // Bus slave registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refresh_control <= CONTROL_RESET;
         wr_pend <= 1'h0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         refresh_control <= next_control;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_rdata;
      end
   end

   // Insertion is held off in release, sleep and wait states
   assign blocked = bus_released | sleep_mode | !wait_pin
      | wait_gen_active;
   assign active = (state != RF_IDLE);
   // A cycle begins only at a machine cycle boundary
   assign start = (state == RF_IDLE) & cycle_boundary & pending
      & refresh_on_bit & !blocked;
   assign cycle_end = (state == RF_T2);

   // Refresh engine: pending flag, cycle states, row counter
   always_comb begin
      next_state = state;
      // A fresh tick wins over the clear; one flag holds any number
      next_pending = (tick & refresh_on_bit)
         | (pending & !start);
      next_row = row;
      unique case (state)
         RF_IDLE: begin
            if (start) begin
               next_state = RF_T1;
            end
         end
         RF_T1: begin
            // Wait pin plays no part in the length
            next_state = refresh_extra_wait_bit ? RF_TRW : RF_T2;
         end
         RF_TRW: begin
            next_state = RF_T2;
         end
         RF_T2: begin
            next_state = RF_IDLE;
            next_row = row + 8'h01;
         end
         default: begin
            next_state = RF_IDLE;
         end
      endcase
   end

   // Refresh engine registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= RF_IDLE;
         pending <= 1'h0;
         row <= ROW_RESET;
      end else begin
         state <= next_state;
         pending <= next_pending;
         row <= next_row;
      end
   end

   // Memory bus image of the cycle, all from flops
   always_comb begin
      bus.refresh_n = !active;
      bus.addr_oe = active;
      bus.row = row;
      bus.strobe_inhibit = active;
   end

   assign refresh_n = bus.refresh_n;
   assign addr_oe = bus.addr_oe;
   assign row_addr = bus.row;
   assign strobe_inhibit = bus.strobe_inhibit;
   // CPU is frozen for the whole cycle; external wait masked then
   assign cpu_hold = active;
   assign cpu_wait = (!wait_pin | wait_gen_active) & !active;

   // Cycle shapes, seen from the first strobe-low clock; the length is
   // judged from T1 because a control write may land on the start edge
   sequence s_short;
      !refresh_n ##1 !refresh_n ##1 refresh_n;
   endsequence

   sequence s_long;
      !refresh_n [*3] ##1 refresh_n;
   endsequence

   // Bus regained with a request waiting and nothing else in the way
   sequence s_release_exit;
      bus_released ##1 (!bus_released && !blocked && pending && !active
         && refresh_on_bit && cycle_boundary);
   endsequence

   // Sleep left with a latched request and nothing else in the way
   sequence s_sleep_exit;
      sleep_mode ##1 (!sleep_mode && !blocked && pending && !active
         && refresh_on_bit && cycle_boundary);
   endsequence

   // Where and when a cycle may start
   a_start_boundary:
      assert property (@(posedge hclk) disable iff (!hresetn)
         $fell(refresh_n) |-> $past(cycle_boundary))
      else $error("refresh started off a boundary");

   a_no_blocked:
      assert property (@(posedge hclk) disable iff (!hresetn)
         $fell(refresh_n) |-> !$past(blocked) && $past(refresh_on_bit))
      else $error("refresh inserted while blocked or disabled");

   a_blocked_idle:
      assert property (@(posedge hclk) disable iff (!hresetn)
         blocked && !active |=> refresh_n)
      else $error("refresh began while blocked");

   a_release_serve:
      assert property (@(posedge hclk) disable iff (!hresetn)
         s_release_exit |=> !refresh_n)
      else $error("held request not served after bus release");

   a_sleep_serve:
      assert property (@(posedge hclk) disable iff (!hresetn)
         s_sleep_exit |=> !refresh_n)
      else $error("held request not served after sleep");

   // Pending request bookkeeping
   a_pending_kept:
      assert property (@(posedge hclk) disable iff (!hresetn)
         pending && !start |=> pending)
      else $error("pending refresh lost");

   a_one_pending:
      assert property (@(posedge hclk) disable iff (!hresetn)
         start && !tick |=> !pending)
      else $error("serviced request still pending");

   a_tick_latch:
      assert property (@(posedge hclk) disable iff (!hresetn)
         tick && refresh_on_bit |=> pending)
      else $error("timer tick not latched");

   a_off_no_latch:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !refresh_on_bit && !pending |=> !pending)
      else $error("request latched while disabled");

   // Cycle length
   a_short_cycle:
      assert property (@(posedge hclk) disable iff (!hresetn)
         state == RF_T1 && !refresh_extra_wait_bit |-> s_short)
      else $error("short refresh not two clocks");

   a_long_cycle:
      assert property (@(posedge hclk) disable iff (!hresetn)
         state == RF_T1 && refresh_extra_wait_bit |-> s_long)
      else $error("long refresh not three clocks");

   // Row counter
   a_row_step:
      assert property (@(posedge hclk) disable iff (!hresetn)
         $rose(refresh_n) |-> row_addr == $past(row_addr) + 8'h01)
      else $error("row did not advance after refresh");

   a_row_hold:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !cycle_end |=> $stable(row_addr))
      else $error("row changed without a refresh");

   // Bus image and processor control
   a_wait_masked:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !refresh_n |-> !cpu_wait && cpu_hold)
      else $error("wait seen during refresh");

   a_addr_drive:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !refresh_n |-> addr_oe && strobe_inhibit && row_addr == row)
      else $error("refresh bus image wrong");

   a_idle_quiet:
      assert property (@(posedge hclk) disable iff (!hresetn)
         refresh_n |-> !addr_oe && !strobe_inhibit && !cpu_hold)
      else $error("refresh image shown outside a cycle");

   // Register bus
   a_unmapped_zero:
      assert property (@(posedge hclk) disable iff (!hresetn)
         access && !hwrite && haddr != OFS_CONTROL && haddr != OFS_STATUS
         |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

endmodule : dram_refresh_control

// ---- tb/dram_model.sv ----
// Purpose: DRAM side of the refresh bus, watching each refresh cycle
// Assumes: refresh strobe and row come from flops on hclk
// Notes: drives nothing; tallies refreshes and faults
`timescale 1ns/100ps
module dram_model
   import refresh_pkg::*;
(
   // Reset
   input wire logic hresetn,
   // Memory bus
   input wire logic refresh_n,
   input wire logic addr_oe,
   input wire logic [7:0] row_addr,
   input wire logic strobe_inhibit,
   // Tallies
   output int count,
   output int bad
);
   // Latch the row on the strobe fall; small delay lets peers settle
   always @(negedge refresh_n or negedge hresetn) begin
      if (!hresetn) begin
         count = 0;
         bad = 0;
      end else begin
         #1;
         if (row_addr !== 8'(ROW_RESET + count)) bad++;
         if (addr_oe !== 1'b1) bad++;
         if (strobe_inhibit !== 1'b1) bad++;
         count++;
      end
   end
endmodule : dram_model

// ---- tb/dram_refresh_control_bench.sv ----
// Purpose: self-checking bench for the refresh controller
// Assumes: zero-wait slave, one cycle per clock state
// Notes: spacing counted in falling edges of hclk
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dram_refresh_control_bench;
   import refresh_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, rd, hrdata;
   logic [3:0] blk = 4'h0; // Blockers: released, sleep, waitgen, pin
   logic bnd = 1, hro, hresp, cpu_hold, cpu_wait, refresh_n, addr_oe;
   logic [7:0] row_addr;
   logic strobe_inhibit;
   int n_errors = 0, checked = 0, cyc = 0, cnt, bad, g, l, g2, c0;
   logic [6:0] ivl [4] = '{INTERVAL_0, INTERVAL_1, INTERVAL_2, INTERVAL_3};
   assign hready = hro;
   dram_refresh_control dut_u (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hro),
      .hresp(hresp), .hrdata(hrdata), .cycle_boundary(bnd),
      .bus_released(blk[0]), .sleep_mode(blk[1]),
      .wait_gen_active(blk[2]), .wait_n(!blk[3]), .cpu_hold(cpu_hold),
      .cpu_wait(cpu_wait), .refresh_n(refresh_n), .addr_oe(addr_oe),
      .row_addr(row_addr), .strobe_inhibit(strobe_inhibit));
   dram_model ram_u (.hresetn(hresetn), .refresh_n(refresh_n),
      .addr_oe(addr_oe), .row_addr(row_addr),
      .strobe_inhibit(strobe_inhibit), .count(cnt), .bad(bad));
   initial begin
      forever #25 hclk = !hclk;
   end
   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // One single-word transfer; read data taken at the data-phase edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hsel <= 0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      `CHK("hresp", 1'b0, hresp)
      q = hrdata;
   endtask : xfer
   // Falling edges until the strobe goes low
   task automatic wait_fall(output int n);
      n = 0;
      while (refresh_n !== 1'b0 && n < 400) begin
         @(negedge hclk);
         n++;
      end
   endtask : wait_fall
   // Strobe low length, with CPU hold and wait checked each clock
   task automatic low_len(output int n);
      n = 0;
      while (refresh_n === 1'b0 && n < 9) begin
         `CHK("hold", 1'b1, cpu_hold)
         `CHK("cpu_wait", 1'b0, cpu_wait)
         @(negedge hclk);
         n++;
      end
   endtask : low_len
   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      xfer(0, OFS_CONTROL, 0, rd);
      `CHK("ctrl reset", 32'(CONTROL_RESET), rd)
      wait_fall(g);
      low_len(l);
      `CHK("len reset", 3, l)
      wait_fall(g);
      `CHK("spacing reset", 10, l + g)
      // Wait pin and generator asserted mid-cycle must not stretch it
      @(posedge hclk);
      blk <= 4'hC;
      low_len(l);
      `CHK("len waited", 3, l)
      @(posedge hclk);
      blk <= 4'h0;
      xfer(1, 8'h08, 32'hFF, rd);
      xfer(0, 8'h08, 0, rd);
      `CHK("unmapped", 32'h0, rd)
      xfer(1, OFS_CONTROL, 32'hFF, rd);
      xfer(0, OFS_CONTROL, 0, rd);
      `CHK("ctrl mask", 32'(CONTROL_MASK), rd)
      // Every interval code with two-clock cycles
      for (int s = 0; s < 4; s++) begin
         xfer(1, OFS_CONTROL, 32'h80 | s, rd);
         wait_fall(g);
         low_len(l);
         wait_fall(g);
         low_len(l);
         wait_fall(g);
         `CHK("len short", 2, l)
         `CHK("spacing", 32'(ivl[s]), l + g)
         low_len(l);
      end
      // Disabled: timer ticks pass without cycles
      xfer(1, OFS_CONTROL, 32'h03, rd);
      c0 = cnt;
      repeat (200) @(negedge hclk);
      `CHK("disabled", c0, cnt)
      xfer(1, OFS_CONTROL, 32'hC3, rd);
      // Boundary gone, then each blocker, across two ticks
      for (int w = 0; w < 5; w++) begin
         wait_fall(g);
         c0 = cnt;
         @(posedge hclk);
         if (w == 0) bnd <= 0;
         else blk <= 4'h1 << (w - 1);
         repeat (169) @(negedge hclk);
         `CHK("suppressed", c0, cnt)
         `CHK("cpu_wait", w > 2, cpu_wait)
         @(posedge hclk);
         bnd <= 1;
         blk <= 4'h0;
         wait_fall(g);
         low_len(l);
         `CHK("one pending", c0 + 1, cnt)
         wait_fall(g2);
         `CHK("timer ran", 240, 169 + g + l + g2)
         low_len(l);
      end
      xfer(0, OFS_STATUS, 0, rd);
      `CHK("row", 8'(ROW_RESET + cnt), rd[7:0])
      `CHK("model", 0, bad)
      report_and_stop();
   end
endmodule : dram_refresh_control_bench
